// ---- fpt_fan_ctrl.sv ----
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module fpt_fan_ctrl
	import fpt_pkg::*;
#(
	parameter int PRE_W = 16,
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Fan
	input wire logic tach_in,
	output logic fan_pulse_output_out
);
	typedef struct packed {
		logic [7:0] fan_speed_setting;
		logic [7:0] fan_control;
		logic [7:0] tach_clock_divisor;
		logic [7:0] rdata;
		logic [7:0] speed_hi_hold;
	} fpt_top_s;

	fpt_top_s st, next_st;
	logic pwm_pulse;
	logic [CNT_W-1:0] speed;
	logic speed_valid;
	logic tach_tick;
	logic [PRE_W-1:0] step_cycles;

	// ***************************************
	// Frequency select
	// ***************************************
	// Step length: control register plus one, times eight unless setting bit 7 is set; the shortest
	// step keeps the period at or above the documented minimum.
	function automatic logic [PRE_W-1:0] step_len(input logic [7:0] ctl, input logic fine);
		logic [PRE_W-1:0] s;
		s = PRE_W'(ctl) + 1'b1;
		if (!fine) begin
			s = s << 3;
		end
		if (s * FPT_DUTY_STEPS < PRE_W'(FPT_PERIOD_MIN_CYC)) begin
			s = PRE_W'((FPT_PERIOD_MIN_CYC + FPT_DUTY_STEPS - 1) / FPT_DUTY_STEPS);
		end
		return s;
	endfunction

	assign step_cycles = step_len(st.fan_control, st.fan_speed_setting[7]);

	fpt_pwm #(
		.PRE_W(PRE_W)
	) u_pwm (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.force_high_in(st.fan_speed_setting[FPT_FORCE_BIT]),
		.duty_in(st.fan_speed_setting[FPT_DUTY_MSB:FPT_DUTY_LSB]),
		.step_cycles_in(step_cycles),
		.pulse_out(pwm_pulse),
		.phase_out()
	);

	fpt_tach #(
		.CNT_W(CNT_W)
	) u_tach (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.divisor_in(st.tach_clock_divisor),
		.tach_in(tach_in),
		.speed_out(speed),
		.valid_out(speed_valid),
		.tick_out(tach_tick)
	);

	// ***************************************
	// Register file
	// ***************************************
	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				FPT_SETTING_OFS: next_st.fan_speed_setting = reg_wdata_in;
				FPT_CONTROL_OFS: next_st.fan_control = reg_wdata_in;
				FPT_DIVISOR_OFS: next_st.tach_clock_divisor = reg_wdata_in;
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				FPT_SETTING_OFS: next_st.rdata = st.fan_speed_setting;
				FPT_CONTROL_OFS: next_st.rdata = st.fan_control;
				FPT_DIVISOR_OFS: next_st.rdata = st.tach_clock_divisor;
				FPT_SPEED_LO_OFS: begin
					// High byte latched so a two-read pair is consistent
					next_st.rdata = speed[7:0];
					next_st.speed_hi_hold = speed[15:8];
				end
				FPT_SPEED_HI_OFS: next_st.rdata = st.speed_hi_hold;
				FPT_STATUS_OFS: next_st.rdata = {6'h00, pwm_pulse, speed_valid};
				default: next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st.fan_speed_setting <= FPT_SETTING_RST;
			st.fan_control <= FPT_CONTROL_RST;
			st.tach_clock_divisor <= FPT_DIVISOR_RST;
			st.rdata <= 8'h00;
			st.speed_hi_hold <= 8'h00;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	assign reg_rdata_out = st.rdata;
	// Straight from the pwm flip-flop
	assign fan_pulse_output_out = pwm_pulse;

	rd_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("Read data not idle zero");
	setting_wr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && reg_wr_in && reg_addr_in == FPT_SETTING_OFS && reg_wdata_in[0]
		##1 clk_en_in |=> fan_pulse_output_out)
		else $error("Forced setting not on pin");
	period_min_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		32'(step_cycles) * FPT_DUTY_STEPS >= FPT_PERIOD_MIN_CYC)
		else $error("Period below minimum");
	speed_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!tach_tick |=> $stable(speed))
		else $error("Speed changed without tach tick");
endmodule

// ---- fpt_fan_model.sv ----
`timescale 1ns/10ps
module fpt_fan_model (
	// Clock
	input wire logic clk_in,
	// Drive stage
	input wire logic pulse_in,
	output int high_out,
	output int period_out,
	// Sensor, lengths in clock cycles
	input wire logic [15:0] tach_hi_in,
	input wire logic [15:0] tach_lo_in,
	output logic tach_out
);
	int hc = 0;
	int pc = 0;
	int tc = 0;
	logic last = 1'b0;
	initial begin
		tach_out = 1'b0;
		high_out = 0;
		period_out = 0;
	end
	// Drive stage measures its high time and period from rise to rise
	always @(posedge clk_in) begin
		last <= pulse_in;
		hc <= pulse_in ? hc + 1 : 0;
		pc <= (pulse_in && !last) ? 1 : pc + 1;
		if (!pulse_in && last)
			high_out <= hc;
		if (pulse_in && !last)
			period_out <= pc;
		tc <= tc + 1;
		// Bench keeps high and low lengths long enough for the counter
		if (tc + 1 >= int'(tach_out ? tach_hi_in : tach_lo_in)) begin
			tach_out <= !tach_out;
			tc <= 0;
		end
	end
endmodule

// ---- fpt_pkg.sv ----
package fpt_pkg;

	// ***************************************
	// Register map
	// ***************************************
	localparam logic [3:0] FPT_SETTING_OFS = 4'h0;
	localparam logic [3:0] FPT_CONTROL_OFS = 4'h1;
	localparam logic [3:0] FPT_DIVISOR_OFS = 4'h2;
	localparam logic [3:0] FPT_SPEED_LO_OFS = 4'h3;
	localparam logic [3:0] FPT_SPEED_HI_OFS = 4'h4;
	localparam logic [3:0] FPT_STATUS_OFS = 4'h5;

	// ***************************************
	// Fields and reset values
	// ***************************************
	localparam int FPT_FORCE_BIT = 0;
	localparam int FPT_DUTY_LSB = 1;
	localparam int FPT_DUTY_MSB = 6;
	localparam logic [7:0] FPT_SETTING_RST = 8'h00;
	localparam logic [7:0] FPT_CONTROL_RST = 8'h00;
	localparam logic [7:0] FPT_DIVISOR_RST = 8'h01;

	// ***************************************
	// Timing
	// ***************************************
	localparam int FPT_CLK_PERIOD_PS = 50000;
	localparam int FPT_TACH_BASE_PS = 30520000;
	// Base tick rounded up to whole cycles, at least one
	localparam int FPT_TACH_BASE_CYC =
		(FPT_TACH_BASE_PS + FPT_CLK_PERIOD_PS - 1) / FPT_CLK_PERIOD_PS;
	localparam int FPT_PERIOD_MIN_US = 21;
	localparam int FPT_PERIOD_MAX_US = 25500;
	// Shortest period: 21 us in 50 ns cycles, rounded up
	localparam int FPT_PERIOD_MIN_CYC =
		(FPT_PERIOD_MIN_US * 1000000 + FPT_CLK_PERIOD_PS - 1) / FPT_CLK_PERIOD_PS;
	localparam int FPT_DUTY_STEPS = 64;
	localparam int FPT_TACH_MIN_HIGH = 3;
	localparam int FPT_TACH_MIN_LOW = 1;

endpackage

// ---- fpt_pwm.sv ----
`timescale 1ns/10ps
module fpt_pwm
	import fpt_pkg::*;
#(
	parameter int PRE_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Setting
	input wire logic force_high_in,
	input wire logic [5:0] duty_in,
	input wire logic [PRE_W-1:0] step_cycles_in,
	// Output
	output logic pulse_out,
	output logic [5:0] phase_out
);
	typedef struct packed {
		logic [PRE_W-1:0] pre;
		logic [5:0] phase;
		logic pulse;
	} fpt_pwm_s;

	fpt_pwm_s st, next_st;

	// ***************************************
	// Sixty-four phase steps form one period
	// ***************************************
	always_comb begin
		next_st = st;
		if (st.pre + 1'b1 >= step_cycles_in) begin
			next_st.pre = '0;
			next_st.phase = st.phase + 6'h01;
		end else begin
			next_st.pre = st.pre + 1'b1;
		end
		if (force_high_in) begin
			next_st.pulse = 1'b1;
		end else if (duty_in == 6'h00) begin
			next_st.pulse = 1'b0;
		end else begin
			next_st.pulse = next_st.phase < duty_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st <= '0;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	assign pulse_out = st.pulse;
	assign phase_out = st.phase;

	force_high_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && force_high_in |=> pulse_out)
		else $error("Pulse not high while forced");
	zero_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !force_high_in && duty_in == 6'h00 |=> !pulse_out)
		else $error("Pulse not low at zero duty");
	duty_cmp_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && !force_high_in && duty_in != 6'h00
		|=> pulse_out == (phase_out < $past(duty_in)))
		else $error("Pulse does not follow duty");
endmodule

// ---- fpt_tach.sv ----
`timescale 1ns/10ps
module fpt_tach
	import fpt_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Setting
	input wire logic [7:0] divisor_in,
	input wire logic tach_in,
	// Result
	output logic [CNT_W-1:0] speed_out,
	output logic valid_out,
	output logic tick_out
);
	typedef struct packed {
		logic [9:0] base;
		logic [7:0] div;
		logic tick;
		logic [1:0] high_run;
		logic level;
		logic seen;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] speed;
		logic valid;
	} fpt_tach_s;

	fpt_tach_s st, next_st;

	// ***************************************
	// Tach counter clock and edge qualify
	// ***************************************
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.base + 10'h001 >= 10'(FPT_TACH_BASE_CYC)) begin
			next_st.base = '0;
			// Divisor zero treated as one
			if (st.div + 8'h01 >= divisor_in) begin
				next_st.div = '0;
				next_st.tick = 1'b1;
			end else begin
				next_st.div = st.div + 8'h01;
			end
		end else begin
			next_st.base = st.base + 10'h001;
		end
		if (st.tick) begin
			// Sampled per tach clock, so narrower high glitches are rejected; one low sample clears the level
			if (tach_in) begin
				if (st.high_run != 2'h3) begin
					next_st.high_run = st.high_run + 2'h1;
				end
				if (st.high_run + 2'h1 >= 2'(FPT_TACH_MIN_HIGH)) begin
					next_st.level = 1'b1;
				end
			end else begin
				next_st.high_run = '0;
				next_st.level = 1'b0;
			end
			if (!st.level && next_st.level) begin
				next_st.seen = 1'b1;
				// The rise tick already belongs to the next period
				next_st.count = CNT_W'(1);
				if (st.seen) begin
					next_st.speed = st.count;
					next_st.valid = 1'b1;
				end
			end else if (st.count != '1) begin
				next_st.count = st.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st <= '0;
		end else if (clk_en_in) begin
			st <= next_st;
		end
	end

	assign speed_out = st.speed;
	assign valid_out = st.valid;
	assign tick_out = st.tick;

	sequence base_done_s;
		clk_en_in && st.base + 10'h001 >= 10'(FPT_TACH_BASE_CYC);
	endsequence
	sequence div_done_s;
		st.div + 8'h01 >= divisor_in;
	endsequence
	tick_cause_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		base_done_s and div_done_s |=> tick_out)
		else $error("Tach tick missing");
	tick_lone_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in && st.base + 10'h001 < 10'(FPT_TACH_BASE_CYC) |=> !tick_out)
		else $error("Tach tick out of step");
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench import fpt_pkg::*;;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic tach_in;
	logic fan_pulse_output_out;
	int high_cyc;
	int period_cyc;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	int m;
	int p;
	logic [15:0] tach_hi = 16'(6 * FPT_TACH_BASE_CYC);
	logic [15:0] tach_lo = 16'(2 * FPT_TACH_BASE_CYC);
	logic [7:0] d;
	logic [7:0] h;
	fpt_fan_ctrl fpt_fan_ctrl_inst (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.tach_in(tach_in),
		.fan_pulse_output_out(fan_pulse_output_out)
	);
	fpt_fan_model fpt_fan_model_inst (
		.clk_in(clk_in),
		.pulse_in(fan_pulse_output_out),
		.high_out(high_cyc),
		.period_out(period_cyc),
		.tach_hi_in(tach_hi),
		.tach_lo_in(tach_lo),
		.tach_out(tach_in)
	);
	initial begin
		forever #25 clk_in = !clk_in;
	end
	// ***************************************
	// Bus access and checking
	// ***************************************
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Counts high cycles of the pin over a fixed stretch
	task automatic hold(output int c);
		c = 0;
		repeat (2000) begin
			@(posedge clk_in);
			#1 c += (fan_pulse_output_out === 1'b1);
		end
	endtask
	task automatic pwm(input logic [7:0] ctl, input logic [7:0] set);
		int step;
		step = (ctl + 1) * (set[7] ? 1 : 8);
		if (step * FPT_DUTY_STEPS < FPT_PERIOD_MIN_CYC)
			step = (FPT_PERIOD_MIN_CYC + FPT_DUTY_STEPS - 1) / FPT_DUTY_STEPS;
		wr(FPT_CONTROL_OFS, ctl);
		wr(FPT_SETTING_OFS, set);
		repeat (3 * 64 * step) @(posedge clk_in);
		check(high_cyc, set[6:1] * step);
		check(period_cyc, 64 * step);
	endtask
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard sized a little beyond the whole sequence, counted from the start
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 90000) begin
			bad_count++;
			close_out();
		end
	end
	// ***************************************
	// Sequence
	// ***************************************
	initial begin
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		rd(FPT_SETTING_OFS, d);
		check(d, FPT_SETTING_RST);
		rd(FPT_DIVISOR_OFS, d);
		check(d, FPT_DIVISOR_RST);
		rd(4'hf, d);
		check(d, 8'h00);
		// Force with a nonzero duty: the duty must be ignored
		wr(FPT_SETTING_OFS, 8'h03);
		repeat (2) @(posedge clk_in);
		hold(n);
		check(n, 2000);
		wr(FPT_SETTING_OFS, 8'h80);
		repeat (2) @(posedge clk_in);
		hold(n);
		check(n, 0);
		// A frozen block must not take a write
		clk_en_in <= 1'b0;
		wr(FPT_SETTING_OFS, 8'h01);
		repeat (4) @(posedge clk_in);
		#1 check(fan_pulse_output_out, 1'b0);
		clk_en_in <= 1'b1;
		rd(FPT_SETTING_OFS, d);
		check(d, 8'h80);
		pwm(8'h00, 8'h82);
		pwm(8'h00, 8'hc0);
		pwm(8'h00, 8'hfe);
		pwm(8'h03, 8'h04);
		for (int dv = 0; dv < 4; dv++) begin
			// Tach high three counter clocks, low one, at the slowest divisor
			m = (dv == 3) ? 3 : 2;
			tach_hi <= 16'(3 * m * FPT_TACH_BASE_CYC);
			tach_lo <= 16'(m * FPT_TACH_BASE_CYC);
			wr(FPT_DIVISOR_OFS, 8'(dv));
			p = (dv == 0 ? 1 : dv) * FPT_TACH_BASE_CYC;
			// Long enough for two qualified rises on settled counter clocks
			repeat (8 * m * FPT_TACH_BASE_CYC + 4 * p + FPT_TACH_BASE_CYC) @(posedge clk_in);
			rd(FPT_SPEED_LO_OFS, d);
			rd(FPT_SPEED_HI_OFS, h);
			check({h, d}, 4 * m / (dv == 0 ? 1 : dv));
			rd(FPT_STATUS_OFS, d);
			check(d[0], 1'b1);
		end
		close_out();
	end
endmodule
